// *** design/upc_uart.v ***
`include "upc_regs.vh"

// Functional notes
// - Mode field picks shift mode, 8-bit async, 9-bit fixed /16, 9-bit divided.
// - Filter enable bit turns on multidrop filtering in async modes.
// - 9-bit modes with filter: no receive pending when ninth bit is zero.
// - 8-bit mode with filter: no receive pending without valid stop bit.
// - Receive allow bit gates reception; zero disables the receiver.
// - 9-bit modes, parity off: control bit is the transmitted ninth bit.
// - 9-bit modes, parity off: received ninth bit stored in control bit.
// - Receive pending reads 1, cleared by writing 0; request needs allow bit.
// - In 9-bit modes parity generation replaces the software ninth bit.
// - Separate transmit and receive parity sense bits: 0 even, 1 odd.
// - Parity error bit set on mismatch, zero on a matching frame.
// - Clock select divides system clock by 8, 4, 2 or 1.
// - Transmit pending reads 1, cleared by writing 0; request needs allow.
// - Shift mode: receive pending set after eighth bit shifted in.
// - 8-bit mode: receive pending set at stop bit midpoint.
// - 9-bit modes: receive pending set at ninth bit midpoint.
// - Shift mode: transmit pending set after eighth bit shifted out.
// - Async modes: transmit pending set at start of stop bit.
// - Writing the data buffer starts a transmit shift.
// - High control register resets to zero.
// - Low control register resets to zero.
// - Shift mode receives when pending 0 and allowed; async on start bit.
// - Shift mode moves 8 bits LSB first on data pin; clock on other pin.
// - 8-bit frame: zero start, eight data LSB first, one stop.
module upc_uart (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire       serial_in_pin_i,
  output reg        serial_in_pin_out_q,
  output reg        serial_in_pin_oe_q,
  output reg        serial_out_pin_q,
  output reg        rx_irq_q,
  output reg        tx_irq_q
);

  // Even parity bit makes the ones count even; odd sense inverts it
  function par_bit;
    input [7:0] data;
    input       odd;
    begin
      par_bit = (^data) ^ odd;
    end
  endfunction

  // Oversampling tick position within a bit period
  function os_last;
    input [3:0] cnt;
    begin
      os_last = (cnt == `UPC_OS_LAST);
    end
  endfunction

  function os_mid;
    input [3:0] cnt;
    begin
      os_mid = (cnt == `UPC_OS_MID);
    end
  endfunction

  function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  reg  [7:0]  con_high_q;
  reg  [7:0]  con_low_q;
  reg  [7:0]  baud_divisor_q;
  reg  [7:0]  rx_buffer_q;
  reg  [7:0]  con_high_d;
  reg  [7:0]  con_low_d;

  reg         tx_busy_q;
  reg         tx_m0_rx_q;
  reg  [3:0]  tx_cnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [10:0] tx_frame_q;

  reg         rx_busy_q;
  reg  [3:0]  rx_cnt_q;
  reg  [3:0]  rx_bit_q;
  reg  [7:0]  rx_shift_q;

  wire        os_tick;
  wire [1:0]  mode     = con_high_q[`UPC_H_MODE];
  wire        m0       = (mode == `UPC_MODE_SHIFT);
  wire        nine     = mode[1];
  wire        par_on   = nine & con_low_q[`UPC_L_PAR_GEN];
  wire        wr_high  = reg_wr & addr_is(reg_addr, `UPC_ADDR_CON_HIGH);
  wire        wr_low   = reg_wr & addr_is(reg_addr, `UPC_ADDR_CON_LOW);
  wire        wr_data  = reg_wr & addr_is(reg_addr, `UPC_ADDR_DATA);
  wire        wr_baud  = reg_wr & addr_is(reg_addr, `UPC_ADDR_BAUD);
  wire [3:0]  stop_idx = nine ? `UPC_BIT_STOP9 : `UPC_BIT_STOP8;
  wire [3:0]  rx_last  = nine ? `UPC_BIT_STOP9 : `UPC_BIT_STOP8;

  reg         tx_start;
  reg         m0_rx_start;
  reg         tx_bit_end;
  reg         tx_set;
  reg         m0_rx_set;
  reg         rx_mid;
  reg         rx_frame_evt;
  reg         rx_set;
  reg         ninth_upd;
  reg         perr_upd;
  reg         perr_val;
  reg         tx_ninth;

  upc_baud u_baud (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clk_sel    (con_low_q[`UPC_L_CLK_SEL]),
    .fixed_rate (mode == `UPC_MODE_ASYNC9F),
    .divisor    (baud_divisor_q),
    .os_tick_q  (os_tick)
  );

  always @* begin
    // A data write while a shift is running is dropped
    tx_start     = wr_data & ~tx_busy_q;
    m0_rx_start  = m0 & ~tx_busy_q & ~wr_data & ~con_high_q[`UPC_H_RX_PEND]
                   & con_high_q[`UPC_H_RX_ALLOW];
    tx_bit_end   = tx_busy_q & os_tick & os_last(tx_cnt_q);
    tx_set       = tx_bit_end & ~tx_m0_rx_q &
                   (m0 ? (tx_bit_q == `UPC_BIT_M0_LAST)
                       : ((tx_bit_q + 4'h1) == stop_idx));
    m0_rx_set    = tx_bit_end & tx_m0_rx_q & (tx_bit_q == `UPC_BIT_M0_LAST);
    rx_mid       = rx_busy_q & os_tick & os_mid(rx_cnt_q);
    rx_frame_evt = rx_mid & ~m0 & (rx_bit_q == `UPC_BIT_NINTH);
    // Same test covers stop bit in 8-bit mode and ninth bit in 9-bit modes
    rx_set       = m0_rx_set | (rx_frame_evt &
                   ~(con_high_q[`UPC_H_FILTER] & ~serial_in_pin_i));
    ninth_upd    = rx_frame_evt & nine & ~par_on;
    perr_upd     = rx_frame_evt & par_on;
    perr_val     = serial_in_pin_i !=
                   par_bit(rx_shift_q, con_low_q[`UPC_L_RX_PAR_ODD]);
    tx_ninth     = ~nine ? 1'b1 :
                   par_on ? par_bit(reg_wdata, con_low_q[`UPC_L_TX_PAR_ODD])
                          : con_high_q[`UPC_H_TX_NINTH];
  end

  // Hardware set wins over a software clear in the same cycle
  always @* begin
    con_high_d = con_high_q;
    con_low_d  = con_low_q;
    if (wr_high) begin
      con_high_d[7:1] = reg_wdata[7:1];
      if (!reg_wdata[`UPC_H_RX_PEND])
        con_high_d[`UPC_H_RX_PEND] = 1'b0;
    end
    if (wr_low) begin
      con_low_d[7:1] = reg_wdata[7:1];
      if (!reg_wdata[`UPC_L_TX_PEND])
        con_low_d[`UPC_L_TX_PEND] = 1'b0;
    end
    if (ninth_upd)
      con_high_d[`UPC_H_RX_NINTH] = serial_in_pin_i;
    if (perr_upd)
      con_low_d[`UPC_L_PAR_ERR] = perr_val;
    if (rx_set)
      con_high_d[`UPC_H_RX_PEND] = 1'b1;
    if (tx_set)
      con_low_d[`UPC_L_TX_PEND] = 1'b1;
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      con_high_q     <= `UPC_RESET_CON;
      con_low_q      <= `UPC_RESET_CON;
      baud_divisor_q <= `UPC_RESET_BAUD;
      rx_buffer_q    <= `UPC_RESET_DATA;
      reg_rdata_q    <= 8'h00;
      rx_irq_q       <= 1'b0;
      tx_irq_q       <= 1'b0;
    end else begin
      con_high_q <= con_high_d;
      con_low_q  <= con_low_d;
      if (wr_baud)
        baud_divisor_q <= reg_wdata;
      if (m0_rx_set)
        rx_buffer_q <= tx_frame_q[7:0];
      else if (rx_set)
        rx_buffer_q <= rx_shift_q;
      rx_irq_q <= con_high_d[`UPC_H_RX_PEND] & con_high_d[`UPC_H_RX_IRQ_ALLOW];
      tx_irq_q <= con_low_d[`UPC_L_TX_PEND] & con_low_d[`UPC_L_TX_IRQ_ALLOW];
      if (reg_rd) begin
        case (reg_addr)
          `UPC_ADDR_CON_HIGH: reg_rdata_q <= con_high_q;
          `UPC_ADDR_CON_LOW:  reg_rdata_q <= con_low_q;
          `UPC_ADDR_DATA:     reg_rdata_q <= rx_buffer_q;
          `UPC_ADDR_BAUD:     reg_rdata_q <= baud_divisor_q;
          default:            reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // Transmitter; in shift mode it also runs the clocked receive shift,
  // since both directions share the data pin there
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_q           <= 1'b0;
      tx_m0_rx_q          <= 1'b0;
      tx_cnt_q            <= 4'h0;
      tx_bit_q            <= 4'h0;
      tx_frame_q          <= 11'h7FF;
      serial_out_pin_q    <= 1'b1;
      serial_in_pin_out_q <= 1'b1;
      serial_in_pin_oe_q  <= 1'b0;
    end else if (tx_start) begin
      tx_busy_q  <= 1'b1;
      tx_m0_rx_q <= 1'b0;
      tx_cnt_q   <= 4'h0;
      tx_bit_q   <= 4'h0;
      if (m0) begin
        tx_frame_q          <= {3'h7, reg_wdata};
        serial_in_pin_out_q <= reg_wdata[0];
        serial_in_pin_oe_q  <= 1'b1;
        serial_out_pin_q    <= 1'b0;
      end else begin
        tx_frame_q       <= {1'b1, tx_ninth, reg_wdata, 1'b0};
        serial_out_pin_q <= 1'b0;
      end
    end else if (m0_rx_start) begin
      tx_busy_q          <= 1'b1;
      tx_m0_rx_q         <= 1'b1;
      tx_cnt_q           <= 4'h0;
      tx_bit_q           <= 4'h0;
      serial_in_pin_oe_q <= 1'b0;
      serial_out_pin_q   <= 1'b0;
    end else if (tx_busy_q && os_tick) begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      if (m0) begin
        if (os_mid(tx_cnt_q)) begin
          serial_out_pin_q <= 1'b1;
          if (tx_m0_rx_q)
            tx_frame_q[7:0] <= {serial_in_pin_i, tx_frame_q[7:1]};
        end
        if (os_last(tx_cnt_q)) begin
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == `UPC_BIT_M0_LAST) begin
            tx_busy_q          <= 1'b0;
            serial_out_pin_q   <= 1'b1;
            serial_in_pin_oe_q <= 1'b0;
          end else begin
            serial_out_pin_q <= 1'b0;
            if (!tx_m0_rx_q) begin
              tx_frame_q          <= {1'b1, tx_frame_q[10:1]};
              serial_in_pin_out_q <= tx_frame_q[1];
            end
          end
        end
      end else if (os_last(tx_cnt_q)) begin
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == stop_idx) begin
          tx_busy_q        <= 1'b0;
          serial_out_pin_q <= 1'b1;
        end else begin
          tx_frame_q       <= {1'b1, tx_frame_q[10:1]};
          serial_out_pin_q <= tx_frame_q[1];
        end
      end
    end
  end

  // Asynchronous receiver; a start bit that is high at mid-bit is treated
  // as a glitch and the receiver returns to hunting
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy_q  <= 1'b0;
      rx_cnt_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 8'h00;
    end else if (!con_high_q[`UPC_H_RX_ALLOW] || m0) begin
      rx_busy_q <= 1'b0;
    end else if (!rx_busy_q) begin
      if (os_tick && !serial_in_pin_i) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 4'h0;
        rx_bit_q  <= 4'h0;
      end
    end else if (os_tick) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (os_mid(rx_cnt_q)) begin
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && serial_in_pin_i)
          rx_busy_q <= 1'b0;
        else if (rx_bit_q == rx_last)
          rx_busy_q <= 1'b0;
        else if (rx_bit_q != 4'h0 && rx_bit_q < `UPC_BIT_NINTH)
          rx_shift_q <= {serial_in_pin_i, rx_shift_q[7:1]};
      end
    end
  end

endmodule // upc_uart

// *** design/upc_regs.vh ***
`ifndef UPC_REGS_VH
`define UPC_REGS_VH

// Register addresses on the CPU register port
`define UPC_ADDR_CON_HIGH  8'hEE
`define UPC_ADDR_CON_LOW   8'hEF
`define UPC_ADDR_DATA      8'hF0
`define UPC_ADDR_BAUD      8'hF1

// Reset values
`define UPC_RESET_CON      8'h00
`define UPC_RESET_DATA     8'h00
`define UPC_RESET_BAUD     8'h00

// High control register fields
`define UPC_H_MODE         7:6
`define UPC_H_FILTER       5
`define UPC_H_RX_ALLOW     4
`define UPC_H_TX_NINTH     3
`define UPC_H_RX_NINTH     2
`define UPC_H_RX_IRQ_ALLOW 1
`define UPC_H_RX_PEND      0

// Low control register fields
`define UPC_L_PAR_GEN      7
`define UPC_L_TX_PAR_ODD   6
`define UPC_L_RX_PAR_ODD   5
`define UPC_L_PAR_ERR      4
`define UPC_L_CLK_SEL      3:2
`define UPC_L_TX_IRQ_ALLOW 1
`define UPC_L_TX_PEND      0

// Operating modes
`define UPC_MODE_SHIFT     2'b00
`define UPC_MODE_ASYNC8    2'b01
`define UPC_MODE_ASYNC9F   2'b10
`define UPC_MODE_ASYNC9V   2'b11

// Clock select codes
`define UPC_CLK_DIV8       2'b00
`define UPC_CLK_DIV4       2'b01
`define UPC_CLK_DIV2       2'b10
`define UPC_CLK_DIV1       2'b11

// Oversampling: sixteen ticks per bit, sample on the eighth
`define UPC_OS_LAST        4'hF
`define UPC_OS_MID         4'h7

// Bit indices inside a frame (0 is the start bit)
`define UPC_BIT_M0_LAST    4'h7
`define UPC_BIT_NINTH      4'h9
`define UPC_BIT_STOP8      4'h9
`define UPC_BIT_STOP9      4'hA

`endif

// *** design/upc_baud.v ***
`include "upc_regs.vh"

// Oversampling tick: system clock prescaled by the clock select field,
// then divided by divisor+1 unless the fixed divide-by-16 mode is active.
module upc_baud (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire [1:0] clk_sel,
  input  wire       fixed_rate,
  input  wire [7:0] divisor,
  output reg        os_tick_q
);

  reg  [2:0] pre_q;
  reg  [7:0] div_cnt_q;
  reg        port_tick;

  always @* begin
    case (clk_sel)
      `UPC_CLK_DIV8: port_tick = (pre_q == 3'h7);
      `UPC_CLK_DIV4: port_tick = (pre_q[1:0] == 2'h3);
      `UPC_CLK_DIV2: port_tick = pre_q[0];
      default:       port_tick = 1'b1;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_q     <= 3'h0;
      div_cnt_q <= 8'h00;
      os_tick_q <= 1'b0;
    end else begin
      pre_q     <= pre_q + 3'h1;
      os_tick_q <= 1'b0;
      if (port_tick) begin
        if (fixed_rate) begin
          os_tick_q <= 1'b1;
          div_cnt_q <= 8'h00;
        end else if (div_cnt_q >= divisor) begin
          // >= keeps the counter sane when the divisor is lowered mid-count
          os_tick_q <= 1'b1;
          div_cnt_q <= 8'h00;
        end else begin
          div_cnt_q <= div_cnt_q + 8'h01;
        end
      end
    end
  end

endmodule // upc_baud

// *** test/upc_checker.sv ***
module upc_checker (
  input wire       clk_sys,
  input wire       reset_n,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire       serial_in_pin_i,
  input wire       serial_in_pin_out_q,
  input wire       serial_in_pin_oe_q,
  input wire       serial_out_pin_q,
  input wire       rx_irq_q,
  input wire       tx_irq_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_q;
  logic [1:0] sel_q;
  logic [7:0] div_q;
  wire        fast;
  // Bit-time checks only hold at one tick per clock, so they are gated on it
  assign fast = sel_q == 2'b11 && (div_q == 8'h00 || mode_q == 2'b10);
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= 2'b00;
      sel_q <= 2'b00;
      div_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 8'hEE) mode_q <= reg_wdata[7:6];
      if (reg_addr == 8'hEF) sel_q <= reg_wdata[3:2];
      if (reg_addr == 8'hF1) div_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_reset_idle: assert property (
    $rose(reset_n) |-> serial_out_pin_q && !serial_in_pin_oe_q && !rx_irq_q && !tx_irq_q
      && reg_rdata_q == 8'h00)
    else $error("outputs not idle after reset");
  a_high_readback: assert property (
    reg_wr && reg_addr == 8'hEE ##2 reg_rd && reg_addr == 8'hEE
      |=> reg_rdata_q[7:3] == $past(reg_wdata[7:3], 3))
    else $error("high control readback wrong");
  a_low_readback: assert property (
    reg_wr && reg_addr == 8'hEF ##2 reg_rd && reg_addr == 8'hEF
      |=> {reg_rdata_q[7:5], reg_rdata_q[3:1]}
        == {$past(reg_wdata[7:5], 3), $past(reg_wdata[3:1], 3)})
    else $error("low control readback wrong");
  a_rx_irq_off: assert property (
    reg_wr && reg_addr == 8'hEE && !reg_wdata[1] ##1 !(reg_wr && reg_addr == 8'hEE)
      |=> !rx_irq_q)
    else $error("receive request without allow");
  a_tx_irq_off: assert property (
    reg_wr && reg_addr == 8'hEF && !reg_wdata[1] ##1 !(reg_wr && reg_addr == 8'hEF)
      |=> !tx_irq_q)
    else $error("transmit request without allow");
  a_drive_shift: assert property (
    serial_in_pin_oe_q |-> mode_q == 2'b00)
    else $error("data pin driven outside shift mode");
  a_async_bit: assert property (
    $fell(serial_out_pin_q) && mode_q != 2'b00 && fast |-> !serial_out_pin_q [*8])
    else $error("async low bit too short");
  a_shift_clock: assert property (
    $fell(serial_out_pin_q) && mode_q == 2'b00 && fast
      |-> !serial_out_pin_q [*8] ##1 serial_out_pin_q)
    else $error("shift clock low phase wrong");
endmodule // upc_checker

bind upc_uart upc_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .serial_in_pin_i(serial_in_pin_i), .serial_in_pin_out_q(serial_in_pin_out_q),
  .serial_in_pin_oe_q(serial_in_pin_oe_q), .serial_out_pin_q(serial_out_pin_q),
  .rx_irq_q(rx_irq_q), .tx_irq_q(tx_irq_q));

// *** test/upc_peer.sv ***
module upc_peer (
  input  wire  clk_sys,
  input  wire  tx_line,
  input  wire  data_line,
  output logic drv_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released line sits at the mark level, as its pull-up would hold it
  initial drv_q = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge clk_sys);
      drv_q <= (i == 0) ? 1'b0 : (i == nb + 1) ? stop : d[i - 1];
      repeat (15) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    drv_q <= 1'b1;
  endtask
  task automatic catch_a(output logic [15:0] d, input int nb);
    d = 16'h0000;
    @(negedge tx_line);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge clk_sys);
      d[i] = tx_line;
    end
  endtask
  task automatic send_s(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_line);
      drv_q <= d[i];
    end
    // Hold the last bit past the sampling rise before releasing
    @(posedge tx_line);
    repeat (4) @(posedge clk_sys);
    drv_q <= 1'b1;
  endtask
  task automatic catch_s(output logic [15:0] d);
    d = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_line);
      d[i] = data_line;
    end
  endtask
endmodule // upc_peer

// *** test/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset_n, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata;
  wire  [7:0]  rdata;
  wire         pin, p_out, p_oe, tx_pin, rx_irq, tx_irq, drv;
  int          fails, checked, cyc, n;
  logic [15:0] got;
  logic [7:0]  ra[5]   = '{8'hEE, 8'hEF, 8'hF0, 8'hF1, 8'h10};
  logic [7:0]  t_ee[4] = '{8'h40, 8'hC0, 8'hC8, 8'h88};
  logic [7:0]  t_ef[4] = '{8'h0E, 8'hCE, 8'h8E, 8'h0E};
  logic [8:0]  t_tx[4] = '{9'h0A5, 9'h103, 9'h003, 9'h155};
  logic [7:0]  r_ee[8] = '{8'h52, 8'h72, 8'h42, 8'hD2, 8'hD2, 8'hB2, 8'hB2, 8'hD6};
  logic [7:0]  r_ef[8] = '{8'h0C, 8'h0C, 8'h0C, 8'hAC, 8'hAC, 8'h0C, 8'h0C, 8'h0C};
  logic [8:0]  r_d[8]  = '{9'h03C, 9'h0C3, 9'h0C3, 9'h101, 9'h001, 9'h0AA, 9'h1AA, 9'h033};
  logic [7:0]  r_xh[8] = '{8'h53, 8'h72, 8'h42, 8'hD3, 8'hD3, 8'hB2, 8'hB7, 8'hD3};
  logic [7:0]  r_xl[8] = '{8'h0C, 8'h0C, 8'h0C, 8'hBC, 8'hAC, 8'h0C, 8'h0C, 8'h0C};
  assign pin = p_oe ? p_out : drv;
  upc_uart dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .serial_in_pin_i(pin),
    .serial_in_pin_out_q(p_out), .serial_in_pin_oe_q(p_oe), .serial_out_pin_q(tx_pin),
    .rx_irq_q(rx_irq), .tx_irq_q(tx_irq));
  upc_peer peer (.clk_sys(clk_sys), .tx_line(tx_pin), .data_line(pin), .drv_q(drv));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), {8'h00, exp & m}, {8'h00, rdata & m});
  endtask
  // Counts cycles to the transmit request, then waits 24 cycles, past a stop bit only at one tick per clock
  task automatic wait_tx(input int lo);
    n = 0;
    while (tx_irq !== 1'b1 && n < 700) begin
      @(posedge clk_sys);
      n++;
    end
    chk("pend time", 16'h0001, {15'h0000, n > lo && n < lo + 12});
    repeat (24) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'hEE, 8'hF9);
    rd(8'hEE, 8'hF8);
    wr(8'hEF, 8'hEF);
    rd(8'hEF, 8'hEE);
    for (int i = 0; i < 4; i++) begin
      wr(8'hEE, t_ee[i]);
      wr(8'hEF, t_ef[i]);
      fork
        peer.catch_a(got, i == 0 ? 8 : 9);
        begin
          wr(8'hF0, t_tx[i][7:0]);
          wait_tx(i == 0 ? 138 : 154);
        end
      join
      chk("tx frame", {7'h00, t_tx[i]}, got);
      rd(8'hEF, t_ef[i] | 8'h01);
      wr(8'hEF, 8'h0C);
      rd(8'hEF, 8'h0C);
      chk("tx irq", 16'h0000, {15'h0000, tx_irq});
    end
    // Slow rate: clock divided by 2, divisor 1, so one bit is 64 cycles
    wr(8'hEE, 8'h40);
    wr(8'hF1, 8'h01);
    rd(8'hF1, 8'h01);
    wr(8'hEF, 8'h0A);
    wr(8'hF0, 8'h5C);
    wait_tx(570);
    repeat (48) @(posedge clk_sys);
    rd(8'hEF, 8'h0B);
    wr(8'hF1, 8'h00);
    wr(8'hEE, 8'h00);
    wr(8'hEF, 8'h0E);
    fork
      peer.catch_s(got);
      begin
        wr(8'hF0, 8'h96);
        wait_tx(122);
      end
    join
    chk("shift tx", 16'h0096, got);
    rd(8'hEF, 8'h0F);
    wr(8'hEF, 8'h0C);
    fork
      wr(8'hEE, 8'h12);
      peer.send_s(8'h5A);
    join
    repeat (8) @(posedge clk_sys);
    rd(8'hEE, 8'h13);
    rd(8'hF0, 8'h5A);
    chk("rx irq", 16'h0001, {15'h0000, rx_irq});
    wr(8'hEE, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'hEE, r_ee[i]);
      wr(8'hEF, r_ef[i]);
      peer.send(r_d[i], i < 3 ? 8 : 9, i != 1);
      repeat (4) @(posedge clk_sys);
      rd(8'hEE, r_xh[i], i == 3 || i == 4 ? 8'hFB : 8'hFF);
      rd(8'hEF, r_xl[i]);
      chk("rx irq", {15'h0000, r_xh[i][0]}, {15'h0000, rx_irq});
      if (r_xh[i][0]) rd(8'hF0, r_d[i][7:0]);
    end
    wrap_up;
  end
endmodule // tb
